// >>> verilog/jbl_pkg.sv
package jbl_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / MS_PER_S;
  localparam int unsigned GENKEY_HOLD_MS = 30_000;
  localparam int unsigned JOIN_LIMIT_MS  = 30_000;
  localparam int unsigned RST_HOLD_MS    = 3_000;
  localparam int unsigned RST_QUIET_MS   = 3_000;
  localparam int unsigned PULSE_MIN_MS   = 100;
  localparam int unsigned PULSE_MAX_MS   = 2_000;
  localparam int unsigned SHORT_MAX_MS   = 2_000;
  localparam int unsigned GAP_END_MS     = 2_000;
  localparam int unsigned QUICK_MS       = 125;
  localparam int unsigned SLOW_MS        = 500;
  localparam int unsigned DEBOUNCE_MS    = 20;

  // ----------------------------------------------------------------
  // Counts of presses and blinks
  // ----------------------------------------------------------------
  localparam logic [2:0] PRESS_JOIN   = 3'h1;
  localparam logic [2:0] PRESS_TEST   = 3'h3;
  localparam logic [2:0] PRESS_RESET  = 3'h4;
  localparam logic [3:0] DONE_BLINKS  = 4'h6;
  localparam logic [3:0] FAIL_BLINKS  = 4'h3;
  localparam logic [1:0] TEST_GROUPS  = 2'h3;
  localparam logic [1:0] RESET_GROUP  = 2'h3;

  // Key configuration reported by the key store
  localparam logic [1:0] KEY_NONE  = 2'h0;
  localparam logic [1:0] KEY_NODE  = 2'h1;
  localparam logic [1:0] KEY_ADMIN = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [9:0] {
    LED_IDLE    = 10'h001,
    LED_ADMJOIN = 10'h002,
    LED_NODJOIN = 10'h004,
    LED_XFER    = 10'h008,
    LED_DONE    = 10'h010,
    LED_CANCEL  = 10'h020,
    LED_FAIL    = 10'h040,
    LED_LONG    = 10'h080,
    LED_TEST    = 10'h100,
    LED_RESET   = 10'h200
  } jbl_led_e;

  typedef enum logic [4:0] {
    PB_IDLE  = 5'h01,
    PB_HIGH  = 5'h02,
    PB_LOW   = 5'h04,
    PB_LONG  = 5'h08,
    PB_QUIET = 5'h10
  } jbl_pb_e;

  typedef struct packed {
    logic joinReq;
    logic genKeyReq;
    logic testReq;
    logic factoryReq;
  } jbl_cmd_s;

  typedef struct packed {
    logic       joinActive;
    logic       isAdmin;
    logic       xferActive;
    logic       xferDone;
    logic       xferFail;
    logic       joinCancel;
    logic       radioActive;
    logic [1:0] keyState;
  } jbl_stat_s;

endpackage : jbl_pkg

// >>> verilog/jbl_join_button_led.sv
`timescale 1ns/1ps
// Function
// - Administrator search shows repeating double quick blink, up to 30 s or join end.
// - Node search shows repeating single quick blink for the same bounded period.
// - Key transfer shows continuous quick blinking while it lasts.
// - Key transfer completion shows six slow blinks, then stops.
// - Otherwise indicator is on while the button is sampled high.
// - Join cancel shows one group of two quick blinks, not repeated.
// - Key share or get failure shows slow blink three times.
// - After long hold, repeat slow blink plus two quick blinks while held.
// - Key test shows one, two or three quick blinks per group, three groups.
// - Normal operation: off when idle, on during packet transmit or receive.
// - One short press starts a join, or cancels one in progress.
// - Holding the button 30 s triggers key and address generation.
// - Three short presses trigger the key and address test.
// - Four brief pulses then hold over 3 s request factory reset.
// - Each reset pulse phase, high and low, lasts 0.1 to 2 s.
// - Once reset sequence recognised, blink in groups of three until release.
// - After release, restore factory settings and restart, serial rate 9600.
// - Bad reset timing is ignored; retry only after 3 s low (when a fifth press such as the hold ends the sequence, 2 s low suffices).
// - During the key generation hold, indicator stays on before 30 s.
module jbl_join_button_led
  import jbl_pkg::*;
#(
  parameter int unsigned GENKEY_CYC = GENKEY_HOLD_MS * CYC_PER_MS,
  parameter int unsigned JOIN_CYC   = JOIN_LIMIT_MS * CYC_PER_MS,
  parameter int unsigned RHOLD_CYC  = RST_HOLD_MS * CYC_PER_MS,
  parameter int unsigned QUIET_CYC  = RST_QUIET_MS * CYC_PER_MS,
  parameter int unsigned PMIN_CYC   = PULSE_MIN_MS * CYC_PER_MS,
  parameter int unsigned PMAX_CYC   = PULSE_MAX_MS * CYC_PER_MS,
  parameter int unsigned SHORT_CYC  = SHORT_MAX_MS * CYC_PER_MS,
  parameter int unsigned GAP_CYC    = GAP_END_MS * CYC_PER_MS,
  parameter int unsigned QUICK_CYC  = QUICK_MS * CYC_PER_MS,
  parameter int unsigned SLOW_CYC   = SLOW_MS * CYC_PER_MS,
  parameter int unsigned DEB_CYC    = DEBOUNCE_MS * CYC_PER_MS
)(
  input  wire logic      clk_sys,          // 20 MHz system clock
  input  wire logic      reset_n,          // Async active-low reset
  input  wire logic      joinButtonInput,  // Pushbutton, high when pressed
  input  wire jbl_stat_s stat,             // Join engine and radio status
  output logic           statusLedOutput,  // Indicator LED
  output jbl_cmd_s       cmd               // One-cycle function requests
);

  localparam int CW = 30;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic          sync1;
    logic          sync2;
    logic          deb;
    logic [CW-1:0] debCnt;
    jbl_pb_e       pb;
    logic [CW-1:0] pbCnt;
    logic [2:0]    presses;
    logic          seqOk;
    logic          genSent;
    jbl_led_e      led;
    logic [CW-1:0] ledCnt;
    logic [CW-1:0] joinCnt;
    logic [3:0]    step;
    logic [3:0]    stepMax;
    logic [1:0]    group;
    logic          ledOn;
    jbl_cmd_s      cmd;
  } jbl_state_s;

  jbl_state_s state_q;
  jbl_state_s state_d;
  logic       rstSync1_q;
  logic       rstSync2_q;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end
    else
    begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end

  // Pattern step helper: returns phase length of blink step
  function automatic logic [CW-1:0] phaseLen(input logic slow);
    phaseLen = slow ? CW'(SLOW_CYC) : CW'(QUICK_CYC);
  endfunction : phaseLen

  function automatic logic [CW-1:0] cyc(input int unsigned n);
    cyc = CW'(n);
  endfunction : cyc

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic       pbEdgeUp;
    logic       phaseEnd;
    logic       slowStep;
    jbl_cmd_s   fire;
    pbEdgeUp = 1'b0;
    phaseEnd = 1'b0;
    slowStep = 1'b0;
    fire     = '0;
    state_d  = state_q;

    // Synchroniser then debounce
    state_d.sync1 = joinButtonInput;
    state_d.sync2 = state_q.sync1;
    if (state_q.sync2 == state_q.deb)
      state_d.debCnt = '0;
    else if (state_q.debCnt >= cyc(DEB_CYC))
    begin
      state_d.deb    = state_q.sync2;
      state_d.debCnt = '0;
      pbEdgeUp       = state_q.sync2;
    end
    else
      state_d.debCnt = state_q.debCnt + 1'b1;

    // Press sequence decoding
    state_d.pbCnt = state_q.pbCnt + 1'b1;
    unique case (state_q.pb)
      PB_IDLE:
        if (pbEdgeUp)
        begin
          state_d.pb      = PB_HIGH;
          state_d.pbCnt   = '0;
          state_d.presses = '0;
          state_d.seqOk   = 1'b1;
        end
      PB_HIGH:
        if (state_d.deb == 1'b0)
        begin
          state_d.pb      = PB_LOW;
          state_d.pbCnt   = '0;
          state_d.presses = state_q.presses + 1'b1;
          if (state_q.pbCnt < cyc(PMIN_CYC) || state_q.pbCnt > cyc(PMAX_CYC))
            state_d.seqOk = 1'b0;
          if (state_q.pbCnt > cyc(SHORT_CYC))
            state_d.presses = '0;
        end
        else if (state_q.presses == PRESS_RESET && state_q.seqOk
                 && state_q.pbCnt > cyc(RHOLD_CYC))
        begin
          state_d.pb  = PB_LONG;
          state_d.led = LED_RESET;
        end
        else if (state_q.presses == 3'h0 && state_q.pbCnt >= cyc(GENKEY_CYC))
        begin
          state_d.pb      = PB_LONG;
          state_d.led     = LED_LONG;
          state_d.genSent = 1'b0;
        end
      PB_LOW:
        if (pbEdgeUp)
        begin
          state_d.pb    = PB_HIGH;
          state_d.pbCnt = '0;
          if (state_q.pbCnt < cyc(PMIN_CYC) || state_q.presses > PRESS_RESET)
            state_d.seqOk = 1'b0;
        end
        else if (state_q.pbCnt >= cyc(GAP_CYC))
        begin
          state_d.pb = PB_IDLE;
          if (state_q.presses == PRESS_JOIN)
            fire.joinReq = 1'b1;
          else if (state_q.presses == PRESS_TEST)
            fire.testReq = 1'b1;
          else if (state_q.presses == PRESS_RESET)
          begin
            state_d.pb    = PB_QUIET;
            state_d.pbCnt = '0;
          end
        end
      PB_LONG:
      begin
        if (state_q.led == LED_LONG && !state_q.genSent)
        begin
          fire.genKeyReq  = 1'b1;
          state_d.genSent = 1'b1;
        end
        if (state_d.deb == 1'b0)
        begin
          if (state_q.led == LED_RESET)
            fire.factoryReq = 1'b1;
          state_d.led   = LED_IDLE;
          state_d.pb    = PB_QUIET;
          state_d.pbCnt = '0;
        end
      end
      PB_QUIET:
        if (state_d.deb)
          state_d.pbCnt = '0;
        else if (state_q.pbCnt >= cyc(QUIET_CYC))
          state_d.pb = PB_IDLE;
    endcase
    state_d.cmd = fire;

    // Indicator pattern selection: events start patterns
    if (state_q.led != LED_LONG && state_q.led != LED_RESET)
    begin
      if (stat.joinCancel)
        state_d.led = LED_CANCEL;
      else if (stat.xferFail)
        state_d.led = LED_FAIL;
      else if (stat.xferDone)
        state_d.led = LED_DONE;
      else if (stat.xferActive)
        state_d.led = LED_XFER;
      else if (fire.testReq)
        state_d.led = LED_TEST;
      else if (stat.joinActive && state_q.led == LED_IDLE && state_q.joinCnt == '0)
        state_d.led = stat.isAdmin ? LED_ADMJOIN : LED_NODJOIN;
    end
    if (state_d.led == LED_TEST)
      unique case (stat.keyState)
        KEY_NODE:  state_d.stepMax = 4'h4;
        KEY_ADMIN: state_d.stepMax = 4'h6;
        default:   state_d.stepMax = 4'h2;
      endcase

    // Join search window
    if (!stat.joinActive)
      state_d.joinCnt = '0;
    else if (state_q.joinCnt < cyc(JOIN_CYC))
      state_d.joinCnt = state_q.joinCnt + 1'b1;

    // Steps: even step = on, odd step = off; extra steps are gaps
    slowStep = (state_q.led == LED_DONE) || (state_q.led == LED_FAIL)
               || (state_q.led == LED_LONG && state_q.step < 4'h2);
    phaseEnd = (state_q.ledCnt >= phaseLen(slowStep));
    if (state_q.led != LED_IDLE)
      state_d.ledCnt = phaseEnd ? '0 : state_q.ledCnt + 1'b1;
    if (phaseEnd)
      state_d.step = state_q.step + 1'b1;

    unique case (state_q.led)
      LED_IDLE:
        state_d.ledOn = state_q.deb || stat.radioActive;
      LED_ADMJOIN, LED_NODJOIN:
      begin
        if (phaseEnd && state_q.step == (state_q.led == LED_ADMJOIN ? 4'h7 : 4'h5))
          state_d.step = '0;
        state_d.ledOn = !state_q.step[0] &&
                        state_q.step < (state_q.led == LED_ADMJOIN ? 4'h4 : 4'h2);
        if ((!stat.joinActive || state_q.joinCnt >= cyc(JOIN_CYC))
            && state_d.led == state_q.led)
          state_d.led = LED_IDLE;
      end
      LED_XFER:
      begin
        state_d.ledOn = !state_q.step[0];
        if (!stat.xferActive && state_d.led == state_q.led)
          state_d.led = LED_IDLE;
      end
      LED_DONE, LED_FAIL, LED_CANCEL:
      begin
        state_d.ledOn = !state_q.step[0];
        if (phaseEnd && state_q.step == ((state_q.led == LED_DONE ? DONE_BLINKS :
            state_q.led == LED_FAIL ? FAIL_BLINKS : 4'h2) * 4'h2 - 4'h1))
          state_d.led = LED_IDLE;
      end
      LED_LONG:
      begin
        state_d.ledOn = !state_q.step[0] && state_q.step < 4'h6;
        if (phaseEnd && state_q.step == 4'h7)
          state_d.step = '0;
      end
      LED_TEST, LED_RESET:
      begin
        state_d.ledOn = !state_q.step[0] &&
          state_q.step < (state_q.led == LED_RESET ? 4'h6 : state_q.stepMax);
        if (phaseEnd && state_q.step == (state_q.led == LED_RESET ? 4'h7
                                          : state_q.stepMax + 4'h1))
        begin
          state_d.step  = '0;
          state_d.group = state_q.group + 1'b1;
          if (state_q.led == LED_TEST && state_q.group == TEST_GROUPS - 2'h1)
            state_d.led = LED_IDLE;
          else if (state_q.led == LED_RESET && state_q.group == RESET_GROUP)
            state_d.group = '0;
        end
      end
    endcase

    // Done last so the phase stepping above cannot leak into a new pattern
    if (state_d.led != state_q.led)
    begin
      state_d.ledCnt = '0;
      state_d.step   = '0;
      state_d.group  = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync2_q)
  begin
    if (!rstSync2_q)
    begin
      state_q         <= '0;
      state_q.pb      <= PB_IDLE;
      state_q.led     <= LED_IDLE;
      state_q.stepMax <= 4'h2;
    end
    else
      state_q <= state_d;
  end

  assign statusLedOutput = state_q.ledOn;
  assign cmd             = state_q.cmd;

endmodule : jbl_join_button_led

// >>> testbench/jbl_join_button_led_sva.sv
`timescale 1ns/1ps
// ----------------------------------------
// Checker on the block ports
// ----------------------------------------
module jbl_join_button_led_sva
  import jbl_pkg::*;
#(
  parameter int unsigned GENKEY_CYC = 200,
  parameter int unsigned QUICK_CYC  = 8,
  parameter int unsigned SLOW_CYC   = 16
)(
  input wire logic      clk_sys,         // Clock
  input wire logic      reset_n,         // Reset
  input wire logic      joinButtonInput, // Button
  input wire jbl_stat_s stat,            // Status
  input wire logic      statusLedOutput, // LED
  input wire jbl_cmd_s  cmd              // Requests
);
  logic [15:0] holdCnt;
  logic [15:0] quietCnt;
  logic [7:0]  ledSame;
  logic        ledQ;
  logic        busy;

  assign busy = joinButtonInput | stat.joinActive | stat.xferActive | stat.xferDone
              | stat.xferFail | stat.joinCancel | (|cmd);

  // Counters saturate so long runs never wrap into a false pass
  always_ff @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
    begin
      holdCnt  <= 16'h0000;
      quietCnt <= 16'h0000;
      ledSame  <= 8'h00;
      ledQ     <= 1'b0;
    end
    else
    begin
      holdCnt  <= !joinButtonInput ? 16'h0000 : holdCnt + {15'h0000, holdCnt != 16'hFFFF};
      quietCnt <= busy ? 16'h0000 : quietCnt + {15'h0000, quietCnt != 16'hFFFF};
      ledSame  <= (ledQ != statusLedOutput) ? 8'h00 : ledSame + {7'h00, ledSame != 8'hFF};
      ledQ     <= statusLedOutput;
    end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence longHeld_s;
    holdCnt == GENKEY_CYC && !stat.joinActive;
  endsequence

  join_pulse_a: assert property (cmd.joinReq |=> !cmd.joinReq)
    else $error("join request longer than one cycle");
  press_gap_a: assert property (cmd.joinReq || cmd.testReq |-> !$past(joinButtonInput, 10))
    else $error("press request before button rest");
  genkey_late_a: assert property (cmd.genKeyReq |-> holdCnt >= GENKEY_CYC)
    else $error("key generation before full hold");
  genkey_due_a: assert property (longHeld_s |-> ##[0:20] cmd.genKeyReq)
    else $error("key generation missing after hold");
  factory_rel_a: assert property (cmd.factoryReq |-> !joinButtonInput && $past(joinButtonInput, 12))
    else $error("factory request not on release");
  press_on_a: assert property (holdCnt > 20 && holdCnt < 70 && !stat.joinActive
    && !stat.xferActive |-> statusLedOutput) else $error("LED off while button held");
  idle_radio_a: assert property (quietCnt > 600 && $stable(stat.radioActive)
    |-> statusLedOutput == stat.radioActive) else $error("idle LED not radio activity");
  xfer_blink_a: assert property (stat.xferActive && $past(stat.xferActive, 30)
    && !joinButtonInput |-> ledSame < QUICK_CYC + 3) else $error("transfer LED not blinking");
  long_blink_a: assert property (holdCnt > GENKEY_CYC + 40 |-> ledSame < 2 * SLOW_CYC + 4)
    else $error("long hold LED not blinking");
endmodule : jbl_join_button_led_sva

// >>> testbench/jbl_button_user.sv
`timescale 1ns/1ps
// ----------------------------------------
// Person at the button
// ----------------------------------------
module jbl_button_user
  import jbl_pkg::*;
(
  input  wire logic clk_sys,        // Clock
  output logic      joinButtonInput // Button, pulled low when open
);
  initial joinButtonInput = 1'b0;

  // Released button reads low through the pull-down
  task automatic press(input int hi, input int lo);
    @(posedge clk_sys);
    #2 joinButtonInput = 1'b1;
    repeat (hi) @(posedge clk_sys);
    #2 joinButtonInput = 1'b0;
    repeat (lo) @(posedge clk_sys);
    #2;
  endtask : press

  task automatic burst(input int n, input int hi, input int lo);
    repeat (n) press(hi, lo);
  endtask : burst
endmodule : jbl_button_user

// >>> testbench/join_button_led_ui_tb.sv
`timescale 1ns/1ps
module join_button_led_ui_tb;
  import jbl_pkg::*;
  localparam int unsigned GK = 200;
  localparam int unsigned GP = 40;
  localparam int unsigned QT = 80;
  localparam int unsigned JC = 3000;
  localparam int unsigned RH = 80;
  localparam int unsigned PN = 20;
  localparam int unsigned PX = 60;
  localparam int unsigned QK = 8;
  localparam int unsigned SL = 16;
  localparam int unsigned DB = 4;
  logic      clk_sys = 1'b0;
  logic      reset_n = 1'b0;
  jbl_stat_s stat    = '0;
  logic      joinButtonInput;
  logic      statusLedOutput;
  jbl_cmd_s  cmd;
  logic      ledQ    = 1'b0;
  logic [7:0] rnd    = 8'h51;
  int        errorCnt = 0;
  int        samplesChecked = 0;
  int        ledRises = 0;
  int        reqCnt[4] = '{default: 0};
  int        len;
  int        len2;

  jbl_join_button_led #(.GENKEY_CYC(GK), .JOIN_CYC(JC), .RHOLD_CYC(RH), .QUIET_CYC(QT),
    .PMIN_CYC(PN), .PMAX_CYC(PX), .SHORT_CYC(PX), .GAP_CYC(GP), .QUICK_CYC(QK),
    .SLOW_CYC(SL), .DEB_CYC(DB)) DUT (.clk_sys(clk_sys), .reset_n(reset_n),
    .joinButtonInput(joinButtonInput), .stat(stat), .statusLedOutput(statusLedOutput),
    .cmd(cmd));
  jbl_button_user u_user (.clk_sys(clk_sys), .joinButtonInput(joinButtonInput));

  always #25 clk_sys = ~clk_sys;

  // Sampled mid-cycle so the count never races the design's own clock edge
  always @(negedge clk_sys)
  begin
    for (int i = 0; i < 4; i++)
      if (cmd[i] === 1'b1) reqCnt[i]++;
    if (statusLedOutput === 1'b1 && ledQ === 1'b0) ledRises++;
    ledQ <= statusLedOutput;
  end

  function automatic logic [7:0] lfsrNext(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsrNext

  // Rises in 100 cycles of search: two quick blinks per 8 steps, or one per 6
  function automatic int searchBlinks(input logic admin);
    return admin ? 4 : 2;
  endfunction : searchBlinks

  function automatic int testBlinks(input int k);
    return 3 * (k + 1);
  endfunction : testBlinks

  task automatic rndLen(output int v, input int lo, input int span);
    rnd = lfsrNext(rnd);
    v = lo + rnd % span;
  endtask : rndLen

  task automatic waitCyc(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : waitCyc

  task automatic clr;
    ledRises = 0;
    reqCnt = '{default: 0};
  endtask : clr

  task automatic checkCount(input string nm, input int exp, input int got);
    samplesChecked++;
    if (exp !== got)
    begin
      errorCnt++;
      $display("Error %s expected %0d seen %0d", nm, exp, got);
    end
  endtask : checkCount

  task automatic checkBit(input string nm, input logic exp, input logic got);
    samplesChecked++;
    if (exp !== got)
    begin
      errorCnt++;
      $display("Error %s expected %b seen %b", nm, exp, got);
    end
  endtask : checkBit

  task automatic printVerdict;
    if (errorCnt == 0 && samplesChecked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : printVerdict

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial
  begin
    repeat (30000) @(posedge clk_sys);
    errorCnt++;
    printVerdict;
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    waitCyc(3);
    reset_n = 1'b1;
    waitCyc(700);
    repeat (40)
    begin
      rnd = lfsrNext(rnd);
      stat.radioActive = rnd[0];
      waitCyc(3);
      checkBit("idle led", rnd[0], statusLedOutput);
    end
    stat.radioActive = 1'b0;
    clr;
    rndLen(len, 10, 40);
    u_user.press(len, GP + 20);
    checkCount("join req", 1, reqCnt[3]);
    stat.isAdmin = rnd[1];
    stat.joinActive = 1'b1;
    clr;
    waitCyc(100);
    checkCount("search blinks", searchBlinks(stat.isAdmin), ledRises);
    clr;
    u_user.press(len, GP + 20);
    checkCount("cancel req", 1, reqCnt[3]);
    stat.joinActive = 1'b0;
    waitCyc(2);
    clr;
    stat.joinCancel = 1'b1;
    waitCyc(1);
    stat.joinCancel = 1'b0;
    waitCyc(150);
    checkCount("cancel blinks", 2, ledRises);
    for (int k = 0; k < 3; k++)
    begin
      stat.keyState = k[1:0];
      clr;
      u_user.burst(3, 15 + k * 10, 25);
      waitCyc(650);
      checkCount("test req", 1, reqCnt[1]);
      checkCount("test blinks", 3 + testBlinks(k), ledRises);
    end
    clr;
    stat.xferActive = 1'b1;
    waitCyc(200);
    checkCount("xfer blinks", 1, ledRises >= 8);
    stat.xferActive = 1'b0;
    waitCyc(20);
    clr;
    stat.xferDone = 1'b1;
    waitCyc(1);
    stat.xferDone = 1'b0;
    waitCyc(400);
    checkCount("done blinks", 6, ledRises);
    clr;
    stat.xferFail = 1'b1;
    waitCyc(1);
    stat.xferFail = 1'b0;
    waitCyc(300);
    checkCount("fail blinks", 3, ledRises);
    waitCyc(700);
    clr;
    u_user.press(GK + 60, QT + 20);
    checkCount("genkey req", 1, reqCnt[2]);
    clr;
    u_user.burst(3, 30, 30);
    u_user.press(10, 30);
    u_user.press(120, QT + 20);
    checkCount("bad reset", 0, reqCnt[0]);
    clr;
    repeat (4)
    begin
      rndLen(len, 25, 30);
      rndLen(len2, 25, 14);
      u_user.press(len, len2);
    end
    u_user.press(150, 40);
    checkCount("factory req", 1, reqCnt[0]);
    checkCount("reset blinks", 1, ledRises > 5);
    printVerdict;
  end
endmodule : join_button_led_ui_tb

bind jbl_join_button_led jbl_join_button_led_sva #(.GENKEY_CYC(GENKEY_CYC),
  .QUICK_CYC(QUICK_CYC), .SLOW_CYC(SLOW_CYC)) u_sva (.clk_sys(clk_sys), .reset_n(reset_n),
  .joinButtonInput(joinButtonInput), .stat(stat), .statusLedOutput(statusLedOutput),
  .cmd(cmd));
